// ### verilog/ctu_timer.v
`timescale 1ns/10ps
`default_nettype none
`include "ctu_timer_consts.vh"

module ctu_timer #(
    parameter AW = 8
) (
    input wire clk,
    input wire rst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [AW-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    input wire capture_event_i,
    input wire debug_break_i,
    output reg irq_o,
    output reg wave_o
);

    reg enable_q;
    reg [2:0] counter_mode_select_q;
    reg edge_sel_q;
    reg ev_in_en_q;
    reg capture_irq_en_q;
    reg capture_event_flag_q;
    reg keep_running_in_break_q;
    reg [7:0] wide_access_latch_q;
    reg [15:0] counter_value_q;
    reg [15:0] capture_compare_value_q;
    reg running_q;
    reg ev_prev_q;
    reg [1:0] fp_phase_q;
    reg [31:0] rdata_d;

    // Returns one when the address is word-aligned and no higher than the last register, gaps included.
    function mapped;
        input [AW-1:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a[AW-1:2] <= 4'hD);
        end
    endfunction

    // Byte address of a register: offsets are word indices, the address is index times four.
    function [AW-1:0] waddr;
        input [7:0] off;
        begin
            waddr = {off[AW-3:0], 2'b00};
        end
    endfunction

    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire lane0 = wb_sel_i[0];
    wire wr = req & wb_we_i & lane0 & mapped(wb_adr_i);
    wire rd = req & ~wb_we_i & mapped(wb_adr_i);
    wire [7:0] wbyte = wb_dat_i[7:0];

    wire active = enable_q & ~(debug_break_i & ~keep_running_in_break_q);
    wire ev_rise = capture_event_i & ~ev_prev_q;
    wire ev_fall = ~capture_event_i & ev_prev_q;
    // Edge polarity chosen by the edge bit; inverted polarity is the other edge.
    wire ev_pol = edge_sel_q ? ev_fall : ev_rise;
    wire ev_opp = edge_sel_q ? ev_rise : ev_fall;
    // Events only count while the event input is enabled and the unit is not halted.
    wire ev_ok = active & ev_in_en_q;

    wire m_top = (counter_mode_select_q == `CTU_MODE_PERIODIC) ||
                 (counter_mode_select_q == `CTU_MODE_TIMEOUT) ||
                 (counter_mode_select_q == `CTU_MODE_SINGLE);
    wire m_cap = (counter_mode_select_q == `CTU_MODE_CAPTURE) ||
                 (counter_mode_select_q == `CTU_MODE_FREQ) ||
                 (counter_mode_select_q == `CTU_MODE_PW) ||
                 (counter_mode_select_q == `CTU_MODE_FRQPW);
    wire m_pwm = counter_mode_select_q == `CTU_MODE_PWM8;

    wire top_hit = running_q & active & m_top &
                   (counter_value_q == capture_compare_value_q);
    wire pwm_hit = running_q & active & m_pwm &
                   (counter_value_q[7:0] == capture_compare_value_q[15:8]);
    wire pwm_wrap = running_q & active & m_pwm &
                    (counter_value_q[7:0] == capture_compare_value_q[7:0]);

    // Capture-side events per mode.
    reg cap_load;
    reg cnt_init;
    reg cnt_stop;
    reg cnt_start;
    reg flag_set;
    always @* begin
        cap_load = 1'b0;
        cnt_init = 1'b0;
        cnt_stop = 1'b0;
        cnt_start = 1'b0;
        flag_set = top_hit | pwm_hit;
        if (ev_ok) begin
            case (counter_mode_select_q)
                `CTU_MODE_CAPTURE: begin
                    cap_load = ev_pol;
                    flag_set = flag_set | ev_pol;
                end
                `CTU_MODE_FREQ: begin
                    cap_load = ev_pol;
                    cnt_init = ev_pol;
                    flag_set = flag_set | ev_pol;
                end
                `CTU_MODE_PW: begin
                    cnt_init = ev_pol;
                    cap_load = ev_opp;
                    flag_set = flag_set | ev_opp;
                end
                `CTU_MODE_FRQPW: begin
                    cnt_init = ev_pol & (fp_phase_q == 2'd0);
                    cap_load = ev_opp & (fp_phase_q == 2'd1);
                    cnt_stop = ev_pol & (fp_phase_q == 2'd2);
                    flag_set = flag_set | cnt_stop;
                end
                `CTU_MODE_TIMEOUT: begin
                    cnt_start = ev_pol;
                    cnt_stop = ev_opp;
                end
                `CTU_MODE_SINGLE: begin
                    cnt_start = ev_rise | (edge_sel_q & ev_fall);
                end
                default: begin
                    cap_load = 1'b0;
                end
            endcase
        end
    end

    // Capture read in capture mode clears the flag.
    // Only the low byte read clears, so a wide read that starts low clears once.
    // Software reading just the high byte sees the latch and leaves the flag alone.
    wire cc_read_clear = rd & m_cap & (wb_adr_i == waddr(`CTU_OFF_CC_LO));
    wire flag_w1c = wr & (wb_adr_i == waddr(`CTU_OFF_IRQFLAGS)) & wbyte[`CTU_BIT_EVFLAG];

    // Bus answer: one cycle after the request, error on unmapped addresses.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req & mapped(wb_adr_i);
            wb_err_o <= req & ~mapped(wb_adr_i);
            wb_dat_o <= rd ? rdata_d : 32'h00000000;
        end
    end

    // Read mux; reading a low byte of a wide register parks the high byte in the latch.
    always @* begin
        // Default zero keeps the unused upper lanes and reserved bits quiet.
        // Gaps in the map read as zero; the error answer covers only the
        // addresses past the last register or off the word grid.
        rdata_d = 32'h00000000;
        if (wb_adr_i == waddr(`CTU_OFF_CTRL)) begin
            rdata_d[`CTU_BIT_ENABLE] = enable_q;
        end else if (wb_adr_i == waddr(`CTU_OFF_MODE)) begin
            rdata_d[2:0] = counter_mode_select_q;
        end else if (wb_adr_i == waddr(`CTU_OFF_EVCTRL)) begin
            rdata_d[`CTU_BIT_EDGE] = edge_sel_q;
            rdata_d[`CTU_BIT_EVIN_EN] = ev_in_en_q;
        end else if (wb_adr_i == waddr(`CTU_OFF_INTEN)) begin
            rdata_d[`CTU_BIT_EVFLAG] = capture_irq_en_q;
        end else if (wb_adr_i == waddr(`CTU_OFF_IRQFLAGS)) begin
            rdata_d[`CTU_BIT_EVFLAG] = capture_event_flag_q;
        end else if (wb_adr_i == waddr(`CTU_OFF_RUNSTATE)) begin
            rdata_d[`CTU_BIT_RUN] = running_q;
        end else if (wb_adr_i == waddr(`CTU_OFF_HALTCTRL)) begin
            rdata_d[`CTU_BIT_KEEPRUN] = keep_running_in_break_q;
        end else if (wb_adr_i == waddr(`CTU_OFF_LATCH)) begin
            rdata_d[7:0] = wide_access_latch_q;
        end else if (wb_adr_i == waddr(`CTU_OFF_CNT_LO)) begin
            rdata_d[7:0] = counter_value_q[7:0];
        end else if (wb_adr_i == waddr(`CTU_OFF_CNT_HI)) begin
            rdata_d[7:0] = wide_access_latch_q;
        end else if (wb_adr_i == waddr(`CTU_OFF_CC_LO)) begin
            rdata_d[7:0] = capture_compare_value_q[7:0];
        end else if (wb_adr_i == waddr(`CTU_OFF_CC_HI)) begin
            // PWM bytes are independent, so the high byte reads directly.
            rdata_d[7:0] = m_pwm ? capture_compare_value_q[15:8] : wide_access_latch_q;
        end else begin
            // Unmapped reads are refused by the error answer and return zero.
            rdata_d = 32'h00000000;
        end
    end

    // Control registers written by software.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= 1'b0;
            counter_mode_select_q <= 3'h0;
            edge_sel_q <= 1'b0;
            ev_in_en_q <= 1'b0;
            capture_irq_en_q <= 1'b0;
            keep_running_in_break_q <= 1'b0;
        end else if (wr) begin
            if (wb_adr_i == waddr(`CTU_OFF_CTRL)) begin
                enable_q <= wbyte[`CTU_BIT_ENABLE];
            end else if (wb_adr_i == waddr(`CTU_OFF_MODE)) begin
                counter_mode_select_q <= wbyte[2:0];
            end else if (wb_adr_i == waddr(`CTU_OFF_EVCTRL)) begin
                edge_sel_q <= wbyte[`CTU_BIT_EDGE];
                ev_in_en_q <= wbyte[`CTU_BIT_EVIN_EN];
            end else if (wb_adr_i == waddr(`CTU_OFF_INTEN)) begin
                capture_irq_en_q <= wbyte[`CTU_BIT_EVFLAG];
            end else if (wb_adr_i == waddr(`CTU_OFF_HALTCTRL)) begin
                keep_running_in_break_q <= wbyte[`CTU_BIT_KEEPRUN];
            end
        end
    end

    // Shared latch: high-byte writes, except the compare high byte in byte PWM, wait here until the low byte commits.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wide_access_latch_q <= `CTU_RST_BYTE;
        end else if (wr && (wb_adr_i == waddr(`CTU_OFF_LATCH) ||
                            wb_adr_i == waddr(`CTU_OFF_CNT_HI) ||
                            (wb_adr_i == waddr(`CTU_OFF_CC_HI) && !m_pwm))) begin
            wide_access_latch_q <= wbyte;
        end else if (rd && wb_adr_i == waddr(`CTU_OFF_CNT_LO)) begin
            // High byte saved on low read.
            wide_access_latch_q <= counter_value_q[15:8];
        end else if (rd && wb_adr_i == waddr(`CTU_OFF_CC_LO)) begin
            // Same parking for the compare pair, so one latch serves both words.
            wide_access_latch_q <= capture_compare_value_q[15:8];
        end
    end

    // Counter and run state; bus write overrides counting in the same cycle.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_value_q <= `CTU_RST_WORD;
            running_q <= 1'b0;
            fp_phase_q <= 2'd0;
            ev_prev_q <= 1'b0;
        end else begin
            // Edge history freezes while halted, so a level change made during a break shows up as an edge once the break ends.
            if (active) begin
                ev_prev_q <= capture_event_i;
            end
            if (!enable_q) begin
                running_q <= 1'b0;
            end else if (cnt_stop || (top_hit &&
                         counter_mode_select_q == `CTU_MODE_SINGLE)) begin
                running_q <= 1'b0;
            end else if (cnt_start || cnt_init ||
                         (!running_q && (counter_mode_select_q != `CTU_MODE_TIMEOUT) &&
                          (counter_mode_select_q != `CTU_MODE_SINGLE) &&
                          (counter_mode_select_q != `CTU_MODE_FRQPW))) begin
                // The combined mode is left out of the free start: after its
                // stop edge it must stay stopped until the next first edge,
                // otherwise the run bit would come back one cycle later and
                // software could never see the measurement as finished.
                running_q <= 1'b1;
            end
            // The phase of the combined mode is cleared whenever that mode is
            // not selected or the unit is off; inside the mode it must survive
            // between edges, so the event update below is the only writer then.
            if (counter_mode_select_q != `CTU_MODE_FRQPW || !enable_q) begin
                fp_phase_q <= 2'd0;
            end
            // Phase walks 0 (wait first edge), 1 (wait opposite), 2 (wait stop).
            if (ev_ok && counter_mode_select_q == `CTU_MODE_FRQPW) begin
                if (cnt_init || cap_load) begin
                    fp_phase_q <= fp_phase_q + 2'd1;
                end else if (cnt_stop) begin
                    fp_phase_q <= 2'd0;
                end
            end
            if (wr && wb_adr_i == waddr(`CTU_OFF_CNT_LO)) begin
                counter_value_q <= {wide_access_latch_q, wbyte};
            end else if (cnt_init) begin
                counter_value_q <= `CTU_RST_WORD;
            end else if (top_hit || (pwm_wrap && !pwm_hit)) begin
                counter_value_q <= `CTU_RST_WORD;
            end else if (running_q && active) begin
                counter_value_q <= counter_value_q + 16'h0001;
            end
        end
    end

    // Capture/compare register; bus writes and captures.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_compare_value_q <= `CTU_RST_WORD;
        end else if (wr && wb_adr_i == waddr(`CTU_OFF_CC_LO)) begin
            // Outside byte PWM the low write commits the latched high byte too.
            capture_compare_value_q <= m_pwm ? {capture_compare_value_q[15:8], wbyte} :
                                               {wide_access_latch_q, wbyte};
        end else if (wr && m_pwm && wb_adr_i == waddr(`CTU_OFF_CC_HI)) begin
            // Byte PWM high byte is written on its own.
            capture_compare_value_q[15:8] <= wbyte;
        end else if (cap_load) begin
            capture_compare_value_q <= counter_value_q;
        end
    end

    // Flag: a hardware set in the same cycle as a clear wins.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_event_flag_q <= 1'b0;
        end else if (flag_set) begin
            capture_event_flag_q <= 1'b1;
        end else if (flag_w1c || cc_read_clear) begin
            // Either a one written to the flag or a capture read in a capture mode.
            // Flag clear.
            capture_event_flag_q <= 1'b0;
        end
    end

    // Interrupt and PWM output from flip-flops.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_o <= 1'b0;
            wave_o <= 1'b0;
        end else begin
            irq_o <= capture_event_flag_q & capture_irq_en_q;
            if (!m_pwm || !running_q) begin
                wave_o <= 1'b0;
            end else if (pwm_wrap) begin
                wave_o <= 1'b1;
            end else if (pwm_hit) begin
                wave_o <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ### verilog/ctu_timer_consts.vh
`ifndef CTU_TIMER_CONSTS_VH
`define CTU_TIMER_CONSTS_VH

// Word indices of the registers (one byte per aligned word on the bus).
`define CTU_OFF_CTRL 8'h00
`define CTU_OFF_MODE 8'h01
`define CTU_OFF_EVCTRL 8'h04
`define CTU_OFF_INTEN 8'h05
`define CTU_OFF_IRQFLAGS 8'h06
`define CTU_OFF_RUNSTATE 8'h07
`define CTU_OFF_HALTCTRL 8'h08
`define CTU_OFF_LATCH 8'h09
`define CTU_OFF_CNT_LO 8'h0A
`define CTU_OFF_CNT_HI 8'h0B
`define CTU_OFF_CC_LO 8'h0C
`define CTU_OFF_CC_HI 8'h0D

// Field positions.
`define CTU_BIT_ENABLE 0
`define CTU_BIT_EVFLAG 0
`define CTU_BIT_RUN 0
`define CTU_BIT_KEEPRUN 0
`define CTU_BIT_EVIN_EN 0
`define CTU_BIT_EDGE 4

// Counter modes.
`define CTU_MODE_PERIODIC 3'h0
`define CTU_MODE_TIMEOUT 3'h1
`define CTU_MODE_CAPTURE 3'h2
`define CTU_MODE_FREQ 3'h3
`define CTU_MODE_PW 3'h4
`define CTU_MODE_FRQPW 3'h5
`define CTU_MODE_SINGLE 3'h6
`define CTU_MODE_PWM8 3'h7

// Reset values.
`define CTU_RST_BYTE 8'h00
`define CTU_RST_WORD 16'h0000

`endif

// ### verif/ctu_timer_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ctu_timer_assertions #(
    parameter AW = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic capture_event_i,
    input wire logic debug_break_i,
    input wire logic irq_o,
    input wire logic wave_o
);
    logic req;
    logic mapped;
    // A fresh request is one the slave has not answered yet.
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign mapped = (wb_adr_i <= AW'(8'h34)) && (wb_adr_i[1:0] == 2'b00);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_err_single_pulse: assert property (wb_err_o |=> !wb_err_o)
        else $error("err held longer than one cycle");
    a_answer_next_cycle: assert property (req |=> (wb_ack_o ^ wb_err_o))
        else $error("request not answered in one cycle");
    a_mapped_gets_ack: assert property (req && mapped |=> wb_ack_o)
        else $error("mapped address not acknowledged");
    a_unmapped_gets_err: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped address not refused");
    a_data_idle_zero: assert property (wb_dat_o[31:8] == 24'h000000 &&
        (wb_ack_o || wb_dat_o == 32'h00000000))
        else $error("read data not zero outside a byte answer");
    a_run_bit_only: assert property (wb_ack_o && !wb_we_i && wb_adr_i == AW'(8'h1C)
        |-> wb_dat_o[7:1] == 7'h00) else $error("run status has extra bits");
    a_irq_masked_off: assert property (wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i == AW'(8'h14) && !wb_dat_i[0] |=> ##1 !irq_o)
        else $error("irq stayed high after enable cleared");
    a_reset_quiet: assert property ($rose(rst_n) |-> !wb_ack_o && !wb_err_o && !irq_o)
        else $error("outputs active at reset release");
endmodule
bind ctu_timer ctu_timer_assertions #(.AW(AW)) u_checker (.clk(clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .capture_event_i(capture_event_i),
    .debug_break_i(debug_break_i), .irq_o(irq_o), .wave_o(wave_o));
`default_nettype wire

// ### verif/ctu_event_source.sv
`timescale 1ns/10ps
`default_nettype none
module ctu_event_source (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [7:0] hold,
    output logic ev
);
    logic [7:0] left_q;
    // One request gives one high level lasting hold cycles; a long hold keeps
    // start-on-rise modes running instead of stopping them at the falling edge.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_q <= 8'h00;
            ev <= 1'b0;
        end else if (go) begin
            left_q <= hold;
            ev <= 1'b1;
        end else if (left_q > 8'h01) begin
            left_q <= left_q - 8'h01;
        end else begin
            left_q <= 8'h00;
            ev <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### verif/ctu_timer_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module ctu_timer_bench;
    logic clk, rst_n, cyc, stb, we, go, brk, ack, err, irq, wave, ev, ev_err;
    logic [7:0] adr, rv, sd, hold;
    logic [15:0] ca, cb, cap;
    logic [31:0] dat, dout;
    logic [2:0] topm [3] = '{3'h0, 3'h1, 3'h6};
    int errors = 0;
    int num_checks = 0;
    int hc;
    ctu_timer DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
        .wb_err_o(err), .capture_event_i(ev), .debug_break_i(brk), .irq_o(irq),
        .wave_o(wave));
    ctu_event_source u_src (.clk(clk), .rst_n(rst_n), .go(go), .hold(hold), .ev(ev));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Among the edge modes 3 to 5, only the combined mode stops its counter after two event pulses.
    function automatic logic run_after_two(input logic [2:0] m);
        return m != 3'h5;
    endfunction
    // Classic cycle: hold the request until ack or err, then one idle cycle.
    task automatic bus(input logic w, input logic [7:0] o, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {o[5:0], 2'b00};
        dat <= {24'h000000, d};
        @(posedge clk);
        while (ack !== 1'b1 && err !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        rv = dout[7:0];
        ev_err = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 20) errors++;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        bus(1'b1, o, d);
    endtask
    task automatic rd(input logic [7:0] o);
        bus(1'b0, o, 8'h00);
    endtask
    // Low byte first, so the high byte comes from the shared latch.
    task automatic rd16(input logic [7:0] o, output logic [15:0] w);
        logic [7:0] lo;
        rd(o);
        lo = rv;
        rd(o + 8'h01);
        w = {rv, lo};
    endtask
    task automatic pulse(input logic [7:0] h);
        hold <= h;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (h + 4) @(posedge clk);
    endtask
    task automatic stop_test;
        if (errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Free-running bench clock at 10 MHz.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // The whole sequence needs a little over a thousand cycles; this cuts a hang.
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        stop_test();
    end
    initial begin
        {cyc, stb, we, go, brk} = 5'h00;
        adr = 8'h00;
        dat = 32'h00000000;
        hold = 8'h04;
        sd = 8'h24;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 7; i < 14; i++) begin
            rd(i[7:0]);
            `CHK("reset value", 8'h00, rv)
        end
        repeat (4) begin
            sd = lfsr(sd);
            wr(8'h09, sd);
            rd(8'h09);
            `CHK("latch", sd, rv)
        end
        wr(8'h07, 8'hFF);
        rd(8'h07);
        `CHK("run idle", 8'h00, rv)
        rd(8'h0E);
        `CHK("unmapped err", 1'b1, ev_err)
        sd = lfsr(sd);
        wr(8'h0B, sd);
        wr(8'h0A, ~sd);
        rd16(8'h0A, ca);
        `CHK("counter pair", {sd, ~sd}, ca)
        // Capture on event with the interrupt enabled.
        wr(8'h01, 8'h02);
        wr(8'h04, 8'h01);
        wr(8'h05, 8'h01);
        wr(8'h00, 8'h01);
        rd16(8'h0A, ca);
        pulse(8'h04);
        rd(8'h06);
        `CHK("capture flag", 8'h01, rv)
        `CHK("irq", 1'b1, irq)
        rd16(8'h0C, cap);
        rd16(8'h0A, cb);
        `CHK("capture range", 1'b1, cap > ca && cap < cb)
        rd(8'h06);
        `CHK("read clears", 8'h00, rv)
        `CHK("irq low", 1'b0, irq)
        rd(8'h07);
        `CHK("run", 8'h01, rv)
        wr(8'h0B, 8'h00);
        wr(8'h0A, 8'h00);
        rd(8'h0A);
        `CHK("write wins", 1'b1, rv < 8'h08)
        pulse(8'h04);
        wr(8'h05, 8'h00);
        rd(8'h06);
        `CHK("masked irq", 1'b0, irq)
        wr(8'h05, 8'h01);
        repeat (2) @(posedge clk);
        `CHK("unmasked irq", 1'b1, irq)
        wr(8'h06, 8'h01);
        rd(8'h06);
        `CHK("w1c", 8'h00, rv)
        // A break without keep-running freezes the count and drops events.
        brk <= 1'b1;
        rd16(8'h0A, ca);
        pulse(8'h04);
        rd16(8'h0A, cb);
        `CHK("halted count", ca, cb)
        rd(8'h06);
        `CHK("halted flag", 8'h00, rv)
        wr(8'h08, 8'h01);
        rd16(8'h0A, ca);
        rd16(8'h0A, cb);
        `CHK("keep running", 1'b1, ca !== cb)
        brk <= 1'b0;
        wr(8'h08, 8'h00);
        for (int m = 3; m < 6; m++) begin
            wr(8'h00, 8'h00);
            wr(8'h01, m[7:0]);
            wr(8'h00, 8'h01);
            pulse(8'h04);
            pulse(8'h04);
            rd(8'h06);
            `CHK("edge mode flag", 8'h01, rv)
            rd(8'h07);
            `CHK("edge mode run", run_after_two(m[2:0]), rv[0])
            rd(8'h0C);
            rd(8'h06);
            `CHK("edge mode clear", 8'h00, rv)
        end
        // Top-value modes; timeout and single shot start on the event rise.
        foreach (topm[k]) begin
            sd = lfsr(sd);
            wr(8'h00, 8'h00);
            wr(8'h0D, 8'h00);
            wr(8'h0C, 8'h20 + {4'h0, sd[3:0]});
            wr(8'h0B, 8'h00);
            wr(8'h0A, 8'h00);
            wr(8'h01, {5'h00, topm[k]});
            wr(8'h06, 8'h01);
            wr(8'h00, 8'h01);
            hold <= 8'hC8;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            rd(8'h06);
            `CHK("before top", 8'h00, rv)
            repeat (100) @(posedge clk);
            rd(8'h06);
            `CHK("top flag", 8'h01, rv)
            repeat (120) @(posedge clk);
        end
        // Byte PWM: compare bytes stand alone, not through the latch.
        wr(8'h00, 8'h00);
        wr(8'h01, 8'h07);
        wr(8'h0D, 8'h05);
        wr(8'h0C, 8'h10);
        wr(8'h09, 8'hAA);
        rd(8'h0D);
        `CHK("pwm high byte", 8'h05, rv)
        rd(8'h0C);
        `CHK("pwm low byte", 8'h10, rv)
        wr(8'h06, 8'h01);
        wr(8'h00, 8'h01);
        hc = 0;
        repeat (40) begin
            @(posedge clk);
            hc += int'(wave === 1'b1);
        end
        `CHK("pwm toggles", 1'b1, hc > 0 && hc < 40)
        rd(8'h06);
        `CHK("pwm flag", 8'h01, rv)
        stop_test();
    end
endmodule
`default_nettype wire
